// ==== design/input_function_decoder.sv ====
// Purpose: Decodes multi-function digital input terminals into drive sequencing commands.
// Assumes: Terminal pins and operator reset key are asynchronous; other inputs share ref_clk.
// Notes: Registers on classic Wishbone; all state is one struct registered once.
// Contract
// RL1: Terminal with code 12 closed jogs forward at jog speed, no run needed.
// RL2: Code 13 jogs in reverse; both jog codes assign independently.
// RL3: Active jog wins over every other speed reference.
// RL4: Reverse prohibit set to 1 makes reverse jog ignored.
// RL5: Both jogs active 500 ms or more raise alarm and ramp to stop.
// RL6: Fault closes fault contact and coasts; some faults pick another stop.
// RL7: Latched fault clears by code 14 terminal or operator reset key.
// RL8: Fault reset ignored while run command present.
// RL9: Fast stop while running decelerates using the quick stop ramp time.
// RL10: Restart refused until stopped, fast stop released and run removed.
// RL11: Code 15 fast stop on closed contact, code 17 on open contact.
// RL12: Code 18 feeds delay timer; result drives output with function 12.
// RL13: Code 19 closed suspends PID; opening resumes it.
// RL14: Code 1A is upper bit with time select 1 for four time sets.
// RL15: Code 1B terminal open rejects parameter writes; reads still work.
// RL16: Code 1E held 100 ms samples analog reference as held reference.
// RL17: Power loss discards sampled reference, so reference restarts at zero; code zeroes held_ref but speed_target falls back to ext_ref_in.
// RL18: Sample/hold with ramp hold, up/down, offset or up2/down2 flags conflict.
// RL19: Codes 20 to 2F are external faults; terminal number is reported.
// RL20: Even external codes fault on closed contact, odd on open.
// RL21: External codes with bit 1 set detect only while running.
// RL22: External stop: 20-23 ramp, 24-27 coast, 28-2B fast, 2C-2F alarm.
// RL23: Simultaneous-jog timer restarts whenever either jog drops early.
`timescale 1ns/1ps
`default_nettype none
module input_function_decoder
  import drive_input_pkg::*;
#(
  parameter int unsigned JOG_BOTH_LIMIT = drive_input_pkg::JOG_BOTH_CYC,
  parameter int unsigned SAMPLE_HOLD_LIMIT = drive_input_pkg::SAMPLE_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [drive_input_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [drive_input_pkg::NUM_TERM-1:0] term_in,
  input wire logic reset_key_in,
  input wire logic run_cmd_in,
  input wire logic motor_running_in,
  input wire logic motor_stopped_in,
  input wire logic internal_fault_in,
  input wire logic overheat_fault_in,
  input wire logic power_loss_in,
  input wire logic timer_result_in,
  input wire logic [drive_input_pkg::REF_W-1:0] analog_ref_in,
  input wire logic [drive_input_pkg::REF_W-1:0] ext_ref_in,
  output logic [drive_input_pkg::REF_W-1:0] speed_target,
  output logic jog_active,
  output logic jog_reverse,
  output logic jog_alarm,
  output logic fault_contact,
  output logic output_off,
  output logic ramp_stop_req,
  output logic quick_ramp_sel,
  output logic run_enable,
  output logic ext_alarm,
  output logic timer_fn_in,
  output logic out_terminal,
  output logic pid_disable,
  output logic [1:0] accel_time_sel,
  output logic setting_conflict_error
);
  import drive_input_pkg::*;

  typedef struct packed {
    logic [NUM_TERM-1:0] sync1;
    logic [NUM_TERM-1:0] sync2;
    logic key1;
    logic key2;
    logic [NUM_TERM-1:0][CODE_W-1:0] func;
    logic rev_prohibit;
    logic [1:0] overheat_stop;
    logic [7:0] out_fn;
    logic [REF_W-1:0] jog_speed;
    logic [CNT_W-1:0] jog_cnt;
    logic jog_alarm;
    logic fault;
    logic [1:0] fault_stop;
    logic fstop;
    logic [CNT_W-1:0] sh_cnt;
    logic [REF_W-1:0] held_ref;
    logic held_valid;
    logic ext_alarm;
    logic ext_seen;
    logic [3:0] ext_term;
    logic [REF_W-1:0] speed;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // True when any terminal carries a code within [lo, hi]
  function automatic logic code_in(input logic [NUM_TERM-1:0][CODE_W-1:0] f,
                                   input logic [CODE_W-1:0] lo,
                                   input logic [CODE_W-1:0] hi);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (f[i] >= lo && f[i] <= hi) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : code_in

  // True when a terminal carrying the code is closed
  function automatic logic code_closed(input logic [NUM_TERM-1:0][CODE_W-1:0] f,
                                       input logic [NUM_TERM-1:0] pins,
                                       input logic [CODE_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (f[i] == code && pins[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : code_closed

  logic fwd;
  logic rev;
  logic both;
  logic reset_req;
  logic fstop_cmd;
  logic locked;
  logic sh_closed;
  logic ext_hit;
  logic [1:0] ext_stop;
  logic ext_flt;
  logic ext_alm;
  logic [3:0] ext_num;
  logic [CODE_W-1:0] code;
  logic acc;
  logic [31:0] rd;
  logic [31:0] wmask;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = term_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.key1 = reset_key_in;
    st_nxt.key2 = st_r.key1;

    fwd = code_closed(st_r.func, st_r.sync2, FN_JOG_FWD); // [RL1]
    // Reverse jog vanishes entirely under reverse prohibit
    rev = code_closed(st_r.func, st_r.sync2, FN_JOG_REV) & ~st_r.rev_prohibit; // [RL2] [RL4]
    both = fwd & rev;
    reset_req = code_closed(st_r.func, st_r.sync2, FN_FAULT_RESET) | st_r.key2; // [RL7]
    fstop_cmd = code_closed(st_r.func, st_r.sync2, FN_FSTOP_NO); // [RL11]
    sh_closed = code_closed(st_r.func, st_r.sync2, FN_SAMPLE_HOLD);
    locked = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (st_r.func[i] == FN_FSTOP_NC && !st_r.sync2[i]) begin
        fstop_cmd = 1'b1; // [RL11]
      end
      if (st_r.func[i] == FN_LOCKOUT && !st_r.sync2[i]) begin
        locked = 1'b1; // [RL15]
      end
    end

    // External faults: lowest terminal with an active fault is reported
    // Alarm-only terminals must not mask a stopping fault on another terminal
    ext_hit = 1'b0;
    ext_flt = 1'b0;
    ext_alm = 1'b0;
    ext_stop = STOP_RAMP;
    ext_num = 4'h0;
    code = '0;
    for (int i = NUM_TERM - 1; i >= 0; i--) begin
      code = st_r.func[i];
      if (code[7:4] == FN_EXT_FAULT_HI // [RL19]
          && (st_r.sync2[i] ^ code[0]) // [RL20]
          && (!code[1] || motor_running_in)) begin // [RL21]
        ext_hit = 1'b1;
        ext_num = 4'(i + 1); // [RL19]
        if (code[3:2] == STOP_ALARM) begin
          ext_alm = 1'b1; // [RL22]
        end else begin
          ext_flt = 1'b1;
          ext_stop = code[3:2]; // [RL22]
        end
      end
    end

    // Simultaneous jog timer, restarted when either jog drops
    if (!both) begin
      st_nxt.jog_cnt = '0; // [RL23]
      st_nxt.jog_alarm = 1'b0;
    end else if (st_r.jog_cnt >= CNT_W'(JOG_BOTH_LIMIT - 1)) begin
      st_nxt.jog_alarm = 1'b1; // [RL5]
    end else begin
      st_nxt.jog_cnt = st_r.jog_cnt + CNT_W'(1);
    end

    // Fault latch; a new fault wins over a reset in the same cycle
    if (reset_req && !run_cmd_in) begin
      st_nxt.fault = 1'b0; // [RL7] [RL8]
    end
    if (ext_flt) begin
      st_nxt.fault = 1'b1; // [RL22]
      st_nxt.fault_stop = ext_stop;
    end
    if (overheat_fault_in) begin
      st_nxt.fault = 1'b1; // [RL6]
      st_nxt.fault_stop = st_r.overheat_stop;
    end
    if (internal_fault_in) begin
      st_nxt.fault = 1'b1; // [RL6]
      st_nxt.fault_stop = STOP_COAST;
    end
    st_nxt.ext_alarm = ext_alm; // [RL22]
    if (ext_hit) begin
      st_nxt.ext_seen = 1'b1;
      st_nxt.ext_term = ext_num;
    end else if (!st_nxt.fault) begin
      st_nxt.ext_seen = 1'b0;
    end

    // Fast stop latch holds off restart until all three release conditions
    if (motor_stopped_in && !fstop_cmd && !run_cmd_in) begin
      st_nxt.fstop = 1'b0; // [RL10]
    end
    if (fstop_cmd && (motor_running_in || st_r.fstop)) begin
      st_nxt.fstop = 1'b1; // [RL9]
    end

    // Sample/hold: one sample per closure once held long enough
    if (!sh_closed) begin
      st_nxt.sh_cnt = '0;
    end else if (st_r.sh_cnt < CNT_W'(SAMPLE_HOLD_LIMIT - 1)) begin
      st_nxt.sh_cnt = st_r.sh_cnt + CNT_W'(1);
    end else if (st_r.sh_cnt == CNT_W'(SAMPLE_HOLD_LIMIT - 1)) begin
      st_nxt.sh_cnt = st_r.sh_cnt + CNT_W'(1);
      st_nxt.held_ref = analog_ref_in; // [RL16]
      st_nxt.held_valid = 1'b1;
    end
    if (power_loss_in) begin
      st_nxt.held_ref = '0; // [RL17]
      st_nxt.held_valid = 1'b0;
    end

    // Jog target overrides held and external references
    if ((fwd ^ rev) && !st_r.jog_alarm) begin
      st_nxt.speed = st_r.jog_speed; // [RL1] [RL3]
    end else if (st_r.held_valid) begin
      st_nxt.speed = st_r.held_ref;
    end else begin
      st_nxt.speed = ext_ref_in;
    end

    // Wishbone slave: one wait state, unmapped reads return zero
    acc = wb_cyc_i & wb_stb_i & ~st_r.ack;
    st_nxt.ack = acc;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    rd = 32'h0000_0000;
    unique case (wb_adr_i)
      ADR_FUNC_LO: rd = st_r.func[3:0];
      ADR_FUNC_HI: rd = st_r.func[7:4];
      ADR_CTRL: begin
        rd[CTRL_REV_PROHIBIT_BIT] = st_r.rev_prohibit;
        rd[CTRL_OVERHEAT_LSB +: 2] = st_r.overheat_stop;
        rd[CTRL_OUT_FN_LSB +: 8] = st_r.out_fn;
      end
      ADR_JOG_SPEED: rd[REF_W-1:0] = st_r.jog_speed;
      ADR_STATUS: begin
        rd[ST_FAULT_BIT] = st_r.fault;
        rd[ST_JOG_ALARM_BIT] = st_r.jog_alarm;
        rd[ST_FSTOP_BIT] = st_r.fstop;
        rd[ST_CONFLICT_BIT] = setting_conflict_error;
        rd[ST_EXT_ALARM_BIT] = st_r.ext_alarm;
        rd[ST_LOCKED_BIT] = locked;
        rd[ST_HELD_VALID_BIT] = st_r.held_valid;
        rd[ST_EXT_SEEN_BIT] = st_r.ext_seen;
        rd[ST_EXT_TERM_LSB +: 4] = st_r.ext_term;
        rd[ST_FAULT_STOP_LSB +: 2] = st_r.fault_stop;
      end
      ADR_HELD_REF: rd[REF_W-1:0] = st_r.held_ref;
      default: rd = 32'h0000_0000;
    endcase
    if (acc && !wb_we_i) begin
      st_nxt.rdata = rd;
    end
    // Locked writes are acknowledged but dropped so the bus never hangs
    if (acc && wb_we_i && !locked) begin // [RL15]
      unique case (wb_adr_i)
        ADR_FUNC_LO: st_nxt.func[3:0] = (st_r.func[3:0] & ~wmask) | (wb_dat_i & wmask);
        ADR_FUNC_HI: st_nxt.func[7:4] = (st_r.func[7:4] & ~wmask) | (wb_dat_i & wmask);
        ADR_CTRL: begin
          if (wb_sel_i[0]) begin
            st_nxt.rev_prohibit = wb_dat_i[CTRL_REV_PROHIBIT_BIT];
            st_nxt.overheat_stop = wb_dat_i[CTRL_OVERHEAT_LSB +: 2];
          end
          if (wb_sel_i[1]) begin
            st_nxt.out_fn = wb_dat_i[CTRL_OUT_FN_LSB +: 8];
          end
        end
        ADR_JOG_SPEED: begin
          if (wb_sel_i[0]) begin
            st_nxt.jog_speed[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            st_nxt.jog_speed[REF_W-1:8] = wb_dat_i[REF_W-1:8];
          end
        end
        default: st_nxt.ack = acc;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.func <= {NUM_TERM{FUNC_RESET}};
      st_r.out_fn <= OUT_FN_RESET;
      st_r.jog_speed <= JOG_SPEED_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdata;
  assign speed_target = st_r.speed;
  assign jog_active = (fwd ^ rev) & ~st_r.jog_alarm; // [RL1] [RL2]
  assign jog_reverse = rev & ~fwd; // [RL2]
  assign jog_alarm = st_r.jog_alarm;
  assign fault_contact = st_r.fault; // [RL6]
  assign output_off = st_r.fault & (st_r.fault_stop == STOP_COAST); // [RL6]
  assign ramp_stop_req = st_r.jog_alarm | (st_r.fault & st_r.fault_stop == STOP_RAMP); // [RL5]
  assign quick_ramp_sel = st_r.fstop | (st_r.fault & st_r.fault_stop == STOP_FAST); // [RL9]
  assign run_enable = ~st_r.fstop & ~st_r.fault; // [RL10]
  assign ext_alarm = st_r.ext_alarm;
  assign timer_fn_in = code_closed(st_r.func, st_r.sync2, FN_TIMER_IN); // [RL12]
  assign out_terminal = (st_r.out_fn == OUT_FN_TIMER) & timer_result_in; // [RL12]
  assign pid_disable = code_closed(st_r.func, st_r.sync2, FN_PID_OFF); // [RL13]
  assign accel_time_sel = {code_closed(st_r.func, st_r.sync2, FN_TIME_SEL2), // [RL14]
                           code_closed(st_r.func, st_r.sync2, FN_TIME_SEL1)};
  assign setting_conflict_error = code_in(st_r.func, FN_SAMPLE_HOLD, FN_SAMPLE_HOLD) // [RL18]
                                  & (code_in(st_r.func, FN_RAMP_HOLD, FN_RAMP_HOLD)
                                     | code_in(st_r.func, FN_UP, FN_DOWN)
                                     | code_in(st_r.func, FN_OFFSET_A, FN_OFFSET_C)
                                     | code_in(st_r.func, FN_UP2, FN_DOWN2));
endmodule : input_function_decoder
`default_nettype wire

// ==== common/drive_input_pkg.sv ====
// Purpose: Shared constants for the multi-function input decoder of a motor drive.
// Assumes: 10 MHz control clock, eight input terminals, classic Wishbone register access.
// Notes: Function codes are the eight-bit values that software writes per terminal.
package drive_input_pkg;
  localparam int NUM_TERM = 8;
  localparam int CODE_W = 8;
  localparam int REF_W = 12;
  localparam int CNT_W = 24;
  localparam int ADR_W = 8;

  // Register byte offsets
  localparam logic [ADR_W-1:0] ADR_FUNC_LO = 8'h00;
  localparam logic [ADR_W-1:0] ADR_FUNC_HI = 8'h04;
  localparam logic [ADR_W-1:0] ADR_CTRL = 8'h08;
  localparam logic [ADR_W-1:0] ADR_JOG_SPEED = 8'h0C;
  localparam logic [ADR_W-1:0] ADR_STATUS = 8'h10;
  localparam logic [ADR_W-1:0] ADR_HELD_REF = 8'h14;

  // Control register fields
  localparam int CTRL_REV_PROHIBIT_BIT = 0;
  localparam int CTRL_OVERHEAT_LSB = 1;
  localparam int CTRL_OUT_FN_LSB = 8;

  // Status register fields
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_JOG_ALARM_BIT = 1;
  localparam int ST_FSTOP_BIT = 2;
  localparam int ST_CONFLICT_BIT = 3;
  localparam int ST_EXT_ALARM_BIT = 4;
  localparam int ST_LOCKED_BIT = 5;
  localparam int ST_HELD_VALID_BIT = 6;
  localparam int ST_EXT_SEEN_BIT = 7;
  localparam int ST_EXT_TERM_LSB = 8;
  localparam int ST_FAULT_STOP_LSB = 12;

  // Reset values
  localparam logic [CODE_W-1:0] FUNC_RESET = 8'h0F;
  localparam logic [7:0] OUT_FN_RESET = 8'h00;
  localparam logic [REF_W-1:0] JOG_SPEED_RESET = 12'h000;

  // Input function codes and the timer output function code
  localparam logic [CODE_W-1:0] FN_TIME_SEL1 = 8'h07;
  localparam logic [CODE_W-1:0] FN_RAMP_HOLD = 8'h0A;
  localparam logic [CODE_W-1:0] FN_UP = 8'h10;
  localparam logic [CODE_W-1:0] FN_DOWN = 8'h11;
  localparam logic [CODE_W-1:0] FN_JOG_FWD = 8'h12;
  localparam logic [CODE_W-1:0] FN_JOG_REV = 8'h13;
  localparam logic [CODE_W-1:0] FN_FAULT_RESET = 8'h14;
  localparam logic [CODE_W-1:0] FN_FSTOP_NO = 8'h15;
  localparam logic [CODE_W-1:0] FN_FSTOP_NC = 8'h17;
  localparam logic [CODE_W-1:0] FN_TIMER_IN = 8'h18;
  localparam logic [CODE_W-1:0] FN_PID_OFF = 8'h19;
  localparam logic [CODE_W-1:0] FN_TIME_SEL2 = 8'h1A;
  localparam logic [CODE_W-1:0] FN_LOCKOUT = 8'h1B;
  localparam logic [CODE_W-1:0] FN_SAMPLE_HOLD = 8'h1E;
  localparam logic [CODE_W-1:0] FN_OFFSET_A = 8'h44;
  localparam logic [CODE_W-1:0] FN_OFFSET_C = 8'h46;
  localparam logic [CODE_W-1:0] FN_UP2 = 8'h75;
  localparam logic [CODE_W-1:0] FN_DOWN2 = 8'h76;
  localparam logic [3:0] FN_EXT_FAULT_HI = 4'h2;
  localparam logic [7:0] OUT_FN_TIMER = 8'h12;

  typedef enum logic [1:0] {
    STOP_RAMP = 2'b00,
    STOP_COAST = 2'b01,
    STOP_FAST = 2'b10,
    STOP_ALARM = 2'b11
  } stop_t;

  // Timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned JOG_BOTH_MS = 500;
  localparam int unsigned SAMPLE_HOLD_MS = 100;
  localparam int unsigned JOG_BOTH_CYC = (CLK_HZ / 1000) * JOG_BOTH_MS;
  localparam int unsigned SAMPLE_HOLD_CYC = (CLK_HZ / 1000) * SAMPLE_HOLD_MS;
endpackage : drive_input_pkg

// ==== tb/fn_decoder_props.sv ====
// Purpose: Port-level properties of the input function decoder.
// Assumes: One ref_clk domain, nrst asynchronous and active low.
// Notes: Bound to every decoder instance.
`timescale 1ns/1ps
`default_nettype none
module fn_decoder_props
  import drive_input_pkg::*;
#(
  parameter int unsigned JOG_BOTH_LIMIT = 20,
  parameter int unsigned SAMPLE_HOLD_LIMIT = 10
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic run_cmd_in,
  input wire logic internal_fault_in,
  input wire logic power_loss_in,
  input wire logic [drive_input_pkg::REF_W-1:0] ext_ref_in,
  input wire logic [drive_input_pkg::REF_W-1:0] speed_target,
  input wire logic jog_active,
  input wire logic fault_contact,
  input wire logic output_off,
  input wire logic quick_ramp_sel,
  input wire logic run_enable,
  input wire logic ext_alarm
);
  import drive_input_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered one cycle later");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_fault_coast: assert property (internal_fault_in |=> fault_contact && output_off)
    else $error("fault did not close contact and cut output");
  a_reset_refused: assert property (fault_contact && run_cmd_in |=> fault_contact)
    else $error("fault cleared while run present");
  a_fault_norun: assert property (fault_contact |-> !run_enable)
    else $error("run allowed while faulted");
  a_fstop_norun: assert property (quick_ramp_sel |-> !run_enable)
    else $error("restart allowed during fast stop");
  a_alarm_runs: assert property (ext_alarm && !fault_contact |-> !output_off)
    else $error("alarm-only fault cut the output");
  a_held_dropped: assert property (
    power_loss_in ##1 !jog_active |=> speed_target == $past(ext_ref_in))
    else $error("held reference survived power loss");
endmodule : fn_decoder_props
bind input_function_decoder fn_decoder_props #(
  .JOG_BOTH_LIMIT(JOG_BOTH_LIMIT),
  .SAMPLE_HOLD_LIMIT(SAMPLE_HOLD_LIMIT)
) u_props (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .run_cmd_in, .internal_fault_in,
  .power_loss_in, .ext_ref_in, .speed_target, .jog_active, .fault_contact, .output_off,
  .quick_ramp_sel, .run_enable, .ext_alarm);
`default_nettype wire

// ==== tb/switch_panel.sv ====
// Purpose: Field side model of terminal contacts, run switch and reset key.
// Assumes: Contacts settle at once; no bounce.
// Notes: High on a terminal means the contact is closed.
`timescale 1ns/1ps
`default_nettype none
module switch_panel (
  input wire logic [7:0] sw,
  input wire logic key_req,
  input wire logic run_req,
  output logic [7:0] term_in,
  output logic reset_key_in,
  output logic run_cmd_in
);
  assign term_in = sw;
  assign run_cmd_in = run_req;
  // Operator drops run before pressing the key
  assign reset_key_in = key_req & !run_req;
endmodule : switch_panel
`default_nettype wire

// ==== tb/drive_input_function_decoder_tb.sv ====
// Purpose: Self-checking bench for the input function decoder.
// Assumes: Shortened jog and sample limits of 20 and 10 cycles.
// Notes: Terminal changes are given four cycles to pass the synchroniser.
`timescale 1ns/1ps
`default_nettype none
module drive_input_function_decoder_tb;
  import drive_input_pkg::*;
  logic ref_clk = 1'h0, nrst = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic [3:0] wb_sel_i = '0;
  logic [7:0] sw = '0, term_in, c;
  logic wb_ack_o, reset_key_in, run_cmd_in, key_req = 1'h0, run_req = 1'h0;
  logic motor_running_in = 1'h0, motor_stopped_in = 1'h1, internal_fault_in = 1'h0;
  logic overheat_fault_in = 1'h0, power_loss_in = 1'h0, timer_result_in = 1'h0;
  logic [REF_W-1:0] analog_ref_in = '0, ext_ref_in = '0, speed_target;
  logic jog_active, jog_reverse, jog_alarm, fault_contact, output_off, ramp_stop_req;
  logic quick_ramp_sel, run_enable, ext_alarm, timer_fn_in, out_terminal, pid_disable;
  logic setting_conflict_error;
  logic [1:0] accel_time_sel;
  logic [7:0] clash [7] = '{8'h0A, 8'h10, 8'h11, 8'h44, 8'h46, 8'h75, 8'h76};
  int n_fail = 0, n_tests = 0, cycles = 0;

  switch_panel u_panel (.sw, .key_req, .run_req, .term_in, .reset_key_in, .run_cmd_in);
  input_function_decoder #(.JOG_BOTH_LIMIT(20), .SAMPLE_HOLD_LIMIT(10)) uut (.ref_clk, .nrst,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
    .term_in, .reset_key_in, .run_cmd_in, .motor_running_in, .motor_stopped_in,
    .internal_fault_in, .overheat_fault_in, .power_loss_in, .timer_result_in, .analog_ref_in,
    .ext_ref_in, .speed_target, .jog_active, .jog_reverse, .jog_alarm, .fault_contact,
    .output_off, .ramp_stop_req, .quick_ramp_sel, .run_enable, .ext_alarm, .timer_fn_in,
    .out_terminal, .pid_disable, .accel_time_sel, .setting_conflict_error);

  always #50 ref_clk = ~ref_clk;

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tk

  // Classic cycle; held until ack is seen, bounded wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    if (wb_ack_o !== 1'h1) n_fail++;
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge ref_clk);
  endtask : wb

  task automatic code(input int t, input logic [7:0] v);
    wb(1'h1, (t < 4) ? ADR_FUNC_LO : ADR_FUNC_HI, {4{v}}, 4'h1 << (t % 4));
  endtask : code

  initial begin
    tk(5);
    nrst <= 1'h1;
    tk(1);
    code(0, FN_JOG_FWD);
    code(1, FN_JOG_REV);
    wb(1'h1, ADR_JOG_SPEED, 32'h0000_0123, 4'hF);
    ext_ref_in <= 12'h456;
    sw <= 8'h01;
    tk(4);
    check({jog_active, jog_reverse}, 2'h2);
    check(speed_target, 12'h123);
    sw <= 8'h02;
    tk(4);
    check({jog_active, jog_reverse}, 2'h3);
    wb(1'h1, ADR_CTRL, 32'h0000_0001, 4'h1);
    tk(2);
    check(jog_active, 1'h0);
    wb(1'h1, ADR_CTRL, 32'h0000_0000, 4'h1);
    sw <= 8'h03;
    tk(15);
    sw <= 8'h01;
    tk(2);
    sw <= 8'h03;
    tk(15);
    check(jog_alarm, 1'h0);
    tk(12);
    check({jog_alarm, ramp_stop_req}, 2'h3);
    sw <= 8'h00;
    internal_fault_in <= 1'h1;
    tk(1);
    internal_fault_in <= 1'h0;
    tk(2);
    check({fault_contact, output_off}, 2'h3);
    code(2, FN_FAULT_RESET);
    run_req <= 1'h1;
    sw <= 8'h04;
    tk(5);
    check(fault_contact, 1'h1);
    run_req <= 1'h0;
    tk(5);
    check(fault_contact, 1'h0);
    sw <= 8'h00;
    tk(3);
    internal_fault_in <= 1'h1;
    tk(1);
    internal_fault_in <= 1'h0;
    key_req <= 1'h1;
    tk(1);
    check(fault_contact, 1'h1);
    tk(4);
    key_req <= 1'h0;
    check(fault_contact, 1'h0);
    wb(1'h1, ADR_CTRL, 32'h0000_0004, 4'h1);
    overheat_fault_in <= 1'h1;
    tk(1);
    overheat_fault_in <= 1'h0;
    tk(2);
    check({fault_contact, output_off, quick_ramp_sel}, 3'h5);
    key_req <= 1'h1;
    tk(5);
    key_req <= 1'h0;
    check(fault_contact, 1'h0);
    foreach (clash[i]) begin
      c = (i == 0) ? FN_FSTOP_NO : FN_FSTOP_NC;
      if (i < 2) begin
        sw <= (c == FN_FSTOP_NC) ? 8'h08 : 8'h00;
        code(3, c);
        {motor_running_in, motor_stopped_in, run_req} <= 3'h5;
        sw <= (c == FN_FSTOP_NC) ? 8'h00 : 8'h08;
        tk(4);
        check({quick_ramp_sel, run_enable}, 2'h2);
        sw <= (c == FN_FSTOP_NC) ? 8'h08 : 8'h00;
        tk(4);
        check(run_enable, 1'h0);
        {motor_running_in, motor_stopped_in, run_req} <= 3'h2;
        tk(4);
        check(run_enable, 1'h1);
      end
    end
    code(3, FUNC_RESET);
    code(5, FN_TIMER_IN);
    sw <= 8'h20;
    wb(1'h1, ADR_CTRL, {16'h0000, OUT_FN_TIMER, 8'h00}, 4'h2);
    timer_result_in <= 1'h1;
    tk(4);
    check({timer_fn_in, out_terminal}, 2'h3);
    code(5, FN_PID_OFF);
    tk(2);
    check(pid_disable, 1'h1);
    sw <= 8'h00;
    tk(4);
    check(pid_disable, 1'h0);
    code(5, FN_TIME_SEL2);
    code(6, FN_TIME_SEL1);
    sw <= 8'h20;
    tk(4);
    check(accel_time_sel, 2'h2);
    sw <= 8'h00;
    code(6, FUNC_RESET);
    code(4, FN_SAMPLE_HOLD);
    analog_ref_in <= 12'hABC;
    sw <= 8'h10;
    tk(16);
    sw <= 8'h00;
    wb(1'h0, ADR_HELD_REF, '0, 4'hF);
    check(q, 32'h0000_0ABC);
    check(speed_target, 12'hABC);
    power_loss_in <= 1'h1;
    tk(1);
    power_loss_in <= 1'h0;
    tk(3);
    check(speed_target, 12'h456);
    foreach (clash[i]) begin
      code(5, clash[i]);
      tk(2);
      check(setting_conflict_error, 1'h1);
    end
    code(5, FUNC_RESET);
    tk(2);
    check(setting_conflict_error, 1'h0);
    code(4, FUNC_RESET);
    for (int i = 0; i < 16; i++) begin
      c = 8'h20 + 8'(i);
      sw <= {1'h0, c[0], 6'h00};
      code(6, c);
      tk(4);
      sw <= {1'h0, !c[0], 6'h00};
      tk(4);
      check({fault_contact, ext_alarm}, {!c[1] && c[3:2] != 2'h3, !c[1] && c[3:2] == 2'h3});
      motor_running_in <= 1'h1;
      tk(4);
      check({fault_contact, ext_alarm}, {c[3:2] != 2'h3, c[3:2] == 2'h3});
      wb(1'h0, ADR_STATUS, '0, 4'hF);
      if (c[3:2] != 2'h3) check(q[13:8], {c[3:2], 4'h7});
      code(6, FUNC_RESET);
      motor_running_in <= 1'h0;
      key_req <= 1'h1;
      tk(4);
      key_req <= 1'h0;
      tk(1);
    end
    code(5, 8'h2C);
    code(6, 8'h24);
    sw <= 8'h60;
    tk(4);
    check({fault_contact, output_off, ext_alarm}, 3'h7);
    sw <= 8'h00;
    code(7, FN_LOCKOUT);
    tk(3);
    wb(1'h1, ADR_JOG_SPEED, 32'h0000_0777, 4'hF);
    wb(1'h0, ADR_JOG_SPEED, '0, 4'hF);
    check(q, 32'h0000_0123);
    sw <= 8'h80;
    tk(4);
    wb(1'h1, ADR_JOG_SPEED, 32'h0000_0777, 4'hF);
    wb(1'h0, ADR_JOG_SPEED, '0, 4'hF);
    check(q, 32'h0000_0777);
    print_verdict();
  end
endmodule : drive_input_function_decoder_tb
`default_nettype wire
